// ==== core/dtc_counter.sv ====
/*
 One count-up timer/event counter with preload, reload on overflow and the
 three operating modes. Width is a parameter.
 Assumes the pin is synchronous to pclk and tick is a one-cycle strobe.
*/
`default_nettype none
module dtc_counter
    import dtc_pkg::*;
#(
    parameter int W = 8
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic tick,
    input wire logic pin,
    input wire dtc_ctrl_s ctrl,
    input wire logic [W-1:0] load_data,
    input wire logic load_wr,
    input wire logic hold,
    output logic [W-1:0] count,
    output logic ovf,
    output logic pulse_done
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic [W-1:0] pre;
        logic pin_d;
        logic armed;
        logic ovf;
        logic done;
    } dtc_cnt_s;
    dtc_cnt_s s_q, s_d;
    logic rise, fall, inc, act_edge, ret_edge;

    // ==========================================
    // Edge detection and increment condition
    always_comb
    begin
        rise = pin & ~s_q.pin_d;
        fall = ~pin & s_q.pin_d;
        act_edge = ctrl.edge_sel ? rise : fall;
        ret_edge = ctrl.edge_sel ? fall : rise;
        inc = 1'b0;
        if (ctrl.run && !hold)
        begin
            case (ctrl.mode)
                DTC_MODE_TIMER: inc = tick;
                DTC_MODE_EVENT: inc = ctrl.edge_sel ? fall : rise;
                DTC_MODE_PULSE: inc = tick & s_q.armed;
                default: inc = 1'b0;
            endcase
        end
    end

    // ==========================================
    // Next state
    always_comb
    begin
        s_d = s_q;
        s_d.pin_d = pin;
        s_d.ovf = 1'b0;
        s_d.done = 1'b0;
        if (!ctrl.run || ctrl.mode != DTC_MODE_PULSE)
        begin
            s_d.armed = 1'b0;
        end
        else if (!s_q.armed && act_edge)
        begin
            s_d.armed = 1'b1;
        end
        else if (s_q.armed && ret_edge)
        begin
            s_d.armed = 1'b0;
            s_d.done = 1'b1;
        end
        if (inc)
        begin
            if (&s_q.cnt)
            begin
                s_d.cnt = s_q.pre;
                s_d.ovf = 1'b1;
            end
            else
            begin
                s_d.cnt = s_q.cnt + 1'b1;
            end
        end
        if (load_wr)
        begin
            s_d.pre = load_data;
            if (!ctrl.run)
            begin
                s_d.cnt = load_data;
            end
        end
    end

    // Register stage
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign count = s_q.cnt;
    assign ovf = s_q.ovf;
    assign pulse_done = s_q.done;

    // ==========================================
    // Assertions
    property p_reload;
        @(posedge pclk) disable iff (!presetn)
        (inc && (&s_q.cnt) && !load_wr) |=> (ovf && count == $past(s_q.pre));
    endproperty
    a_reload: assert property (p_reload) else $error("no reload on overflow");
    property p_stop_load;
        @(posedge pclk) disable iff (!presetn)
        (load_wr && !ctrl.run) |=> (count == $past(load_data));
    endproperty
    a_stop_load: assert property (p_stop_load) else $error("stopped load missed");
    property p_idle;
        @(posedge pclk) disable iff (!presetn)
        (!ctrl.run && !load_wr) |=> (count == $past(count));
    endproperty
    a_idle: assert property (p_idle) else $error("count moved while stopped");
    property p_off_mode;
        @(posedge pclk) disable iff (!presetn)
        (ctrl.mode == DTC_MODE_OFF && !load_wr) |=> (count == $past(count));
    endproperty
    a_off_mode: assert property (p_off_mode) else $error("mode 00 counted");
    property p_ovf_cause;
        @(posedge pclk) disable iff (!presetn)
        ovf |-> $past(inc);
    endproperty
    a_ovf_cause: assert property (p_ovf_cause) else $error("spurious overflow");
    c_ovf: cover property (@(posedge pclk) disable iff (!presetn) ovf);
    c_pulse: cover property (@(posedge pclk) disable iff (!presetn) pulse_done);
endmodule
`default_nettype wire

// ==== core/dtc_pkg.sv ====
/*
 Package for the dual timer/event counter: register offsets, control field
 positions, mode encodings, reset values and carrier structs.
 Assumes a 32-bit APB master and a 20 MHz pclk.
*/
`default_nettype none
package dtc_pkg;
    // ==========================================
    // Register map (byte addresses)
    localparam logic [7:0] DTC_OFS_BYTE_VALUE = 8'h00;
    localparam logic [7:0] DTC_OFS_BYTE_CTRL = 8'h04;
    localparam logic [7:0] DTC_OFS_WORD_LOW = 8'h08;
    localparam logic [7:0] DTC_OFS_WORD_HIGH = 8'h0C;
    localparam logic [7:0] DTC_OFS_WORD_CTRL = 8'h10;
    localparam logic [7:0] DTC_OFS_INT_CTRL = 8'h14;
    localparam logic [7:0] DTC_OFS_STATUS = 8'h18;
    // ==========================================
    // Control register fields
    localparam int DTC_MODE_HI = 7;
    localparam int DTC_MODE_LO = 6;
    localparam int DTC_RUN_BIT = 4;
    localparam int DTC_EDGE_BIT = 3;
    // Interrupt control fields
    localparam int DTC_IE0_BIT = 0;
    localparam int DTC_IE1_BIT = 1;
    localparam int DTC_IF0_BIT = 2;
    localparam int DTC_IF1_BIT = 3;
    // ==========================================
    // Mode encodings
    localparam logic [1:0] DTC_MODE_OFF = 2'h0;
    localparam logic [1:0] DTC_MODE_EVENT = 2'h1;
    localparam logic [1:0] DTC_MODE_TIMER = 2'h2;
    localparam logic [1:0] DTC_MODE_PULSE = 2'h3;
    // ==========================================
    // Reset values and counts
    localparam logic [7:0] DTC_CTRL_RST = 8'h00;
    localparam logic [7:0] DTC_INTERRUPT_CONTROL_REG_RST = 8'h00;
    localparam int DTC_WORD_DIV = 4;
    localparam logic [1:0] DTC_DIV_LAST = 2'h3;
    // ==========================================
    // Carrier structs
    typedef struct packed {
        logic [1:0] mode;
        logic run;
        logic edge_sel;
    } dtc_ctrl_s;
    typedef struct packed {
        logic wr;
        logic [15:0] data;
    } dtc_load_s;
endpackage
`default_nettype wire

// ==== core/dtc_top.sv ====
/*
 Dual timer/event counter: an 8-bit and a 16-bit counter with preload,
 byte-buffered 16-bit access, interrupt enables and an APB register slave.
 Assumes a 32-bit APB master on pclk at 20 MHz; timer pins synchronous.
*/
// The placing of the registers and the APB register port were chosen for this implementation.
`default_nettype none
// How it works
// - Byte counter timer clock is pclk
// - Word counter timer clock is pclk divided by four
// - Event mode counts pin edges, no prescaler
// - Edge select low rising, high falling in event mode; pulse mode starts on falling when low, rising when high
// - Count up, overflow at all ones, request
// - Overflow reloads preload and keeps counting
// - Stopped counter takes preload write at once
// - Running counter takes preload at next overflow
// - Low byte write goes only to buffer
// - High byte write loads high and buffer
// - High read latches low byte for reads
// - Mode field is control bits 7 and 6
// - Control bit 4 runs or stops counter
// - Interrupt enable gates overflow request
// - Event mode counts and wakes in power-down
// - Mode 11 selects pulse width measurement
// - Pulse mode starts on the active edge
// - Pulse end clears run, ignores later edges
module dtc_top
    import dtc_pkg::*;
#(
    parameter int BYTE_W = 8,
    parameter int WORD_W = 16
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic byte_counter_pin,
    input wire logic word_counter_pin,
    output logic irq_byte,
    output logic irq_word,
    output logic wakeup
);
    typedef struct packed {
        logic [7:0] ctrl0;
        logic [7:0] ctrl1;
        logic [7:0] low_buf;
        logic ie0;
        logic ie1;
        logic if0;
        logic if1;
        logic [1:0] div;
        logic [31:0] rdata;
        logic ack;
    } dtc_top_s;
    dtc_top_s s_q, s_d;

    logic acc, wr, rd, tick4, done0, done1, ovf0, ovf1;
    logic [BYTE_W-1:0] cnt0;
    logic [WORD_W-1:0] cnt1;
    dtc_ctrl_s c0, c1;
    dtc_load_s ld0, ld1;
    logic [31:0] rsel;
    logic hit;

    // ==========================================
    // Bus strobes and control views
    assign acc = psel & penable;
    // One wait state: reads capture in the first access cycle, writes land in the second
    assign wr = acc & pwrite & s_q.ack;
    assign rd = acc & ~pwrite & ~s_q.ack;
    assign tick4 = (s_q.div == DTC_DIV_LAST);
    always_comb
    begin
        c0.mode = s_q.ctrl0[DTC_MODE_HI:DTC_MODE_LO];
        c0.run = s_q.ctrl0[DTC_RUN_BIT];
        c0.edge_sel = s_q.ctrl0[DTC_EDGE_BIT];
        c1.mode = s_q.ctrl1[DTC_MODE_HI:DTC_MODE_LO];
        c1.run = s_q.ctrl1[DTC_RUN_BIT];
        c1.edge_sel = s_q.ctrl1[DTC_EDGE_BIT];
        ld0.wr = wr && paddr == DTC_OFS_BYTE_VALUE;
        ld0.data = {8'h00, pwdata[7:0]};
        ld1.wr = wr && paddr == DTC_OFS_WORD_HIGH;
        ld1.data = {pwdata[7:0], s_q.low_buf};
    end

    // ==========================================
    // Counters
    dtc_counter #(.W(BYTE_W)) u_byte (
        .pclk(pclk),
        .presetn(presetn),
        .tick(1'b1),
        .pin(byte_counter_pin),
        .ctrl(c0),
        .load_data(ld0.data[BYTE_W-1:0]),
        .load_wr(ld0.wr),
        .hold(1'b0),
        .count(cnt0),
        .ovf(ovf0),
        .pulse_done(done0)
    );
    dtc_counter #(.W(WORD_W)) u_word (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick4),
        .pin(word_counter_pin),
        .ctrl(c1),
        .load_data(ld1.data[WORD_W-1:0]),
        .load_wr(ld1.wr),
        .hold(1'b0),
        .count(cnt1),
        .ovf(ovf1),
        .pulse_done(done1)
    );

    // ==========================================
    // Read mux
    always_comb
    begin
        rsel = 32'h00000000;
        hit = 1'b1;
        if (paddr == DTC_OFS_BYTE_VALUE)
        begin
            rsel = {24'h000000, cnt0};
        end
        else if (paddr == DTC_OFS_BYTE_CTRL)
        begin
            rsel = {24'h000000, s_q.ctrl0};
        end
        else if (paddr == DTC_OFS_WORD_LOW)
        begin
            rsel = {24'h000000, s_q.low_buf};
        end
        else if (paddr == DTC_OFS_WORD_HIGH)
        begin
            rsel = {24'h000000, cnt1[15:8]};
        end
        else if (paddr == DTC_OFS_WORD_CTRL)
        begin
            rsel = {24'h000000, s_q.ctrl1};
        end
        else if (paddr == DTC_OFS_INT_CTRL)
        begin
            rsel = {28'h0000000, s_q.if1, s_q.if0, s_q.ie1, s_q.ie0};
        end
        else if (paddr == DTC_OFS_STATUS)
        begin
            rsel = {30'h00000000, c1.run, c0.run};
        end
        else
        begin
            hit = 1'b0;
        end
    end

    // ==========================================
    // Next state of registers
    always_comb
    begin
        s_d = s_q;
        s_d.div = s_q.div + 2'h1;
        s_d.ack = acc & ~s_q.ack; // Answer one cycle into the access phase
        if (rd)
        begin
            s_d.rdata = rsel;
        end
        if (wr)
        begin
            if (paddr == DTC_OFS_BYTE_CTRL)
            begin
                s_d.ctrl0 = pwdata[7:0];
            end
            else if (paddr == DTC_OFS_WORD_CTRL)
            begin
                s_d.ctrl1 = pwdata[7:0];
            end
            else if (paddr == DTC_OFS_WORD_LOW)
            begin
                s_d.low_buf = pwdata[7:0];
            end
            else if (paddr == DTC_OFS_INT_CTRL)
            begin
                s_d.ie0 = pwdata[DTC_IE0_BIT];
                s_d.ie1 = pwdata[DTC_IE1_BIT];
                s_d.if0 = pwdata[DTC_IF0_BIT];
                s_d.if1 = pwdata[DTC_IF1_BIT];
            end
        end
        if (rd && paddr == DTC_OFS_WORD_HIGH)
        begin
            s_d.low_buf = cnt1[7:0];
        end
        // Pulse end drops run; hardware clear wins over a write
        if (done0)
        begin
            s_d.ctrl0[DTC_RUN_BIT] = 1'b0;
        end
        if (done1)
        begin
            s_d.ctrl1[DTC_RUN_BIT] = 1'b0;
        end
        // Overflow sets request flag; set wins over clear
        if (ovf0)
        begin
            s_d.if0 = 1'b1;
        end
        if (ovf1)
        begin
            s_d.if1 = 1'b1;
        end
    end

    // Register stage
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ==========================================
    // Outputs
    assign pready = s_q.ack;
    assign prdata = s_q.rdata;
    assign pslverr = acc & ~hit & s_q.ack;
    assign irq_byte = s_q.if0 & s_q.ie0;
    assign irq_word = s_q.if1 & s_q.ie1;
    assign wakeup = ovf0 | ovf1;

    // ==========================================
    // Assertions
    property p_irq_gate;
        @(posedge pclk) disable iff (!presetn)
        (!s_q.ie0) |-> !irq_byte;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq not gated");
    property p_flag_set;
        @(posedge pclk) disable iff (!presetn)
        ovf1 |=> s_q.if1;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag lost");
    property p_low_hold;
        @(posedge pclk) disable iff (!presetn)
        (wr && paddr == DTC_OFS_WORD_LOW && c1.mode == DTC_MODE_OFF)
            |=> (cnt1 == $past(cnt1));
    endproperty
    a_low_hold: assert property (p_low_hold) else $error("low write hit counter");
    property p_high_load;
        @(posedge pclk) disable iff (!presetn)
        (ld1.wr && !c1.run) |=> (cnt1 == {$past(pwdata[7:0]), $past(s_q.low_buf)});
    endproperty
    a_high_load: assert property (p_high_load) else $error("word load wrong");
    property p_latch;
        @(posedge pclk) disable iff (!presetn)
        (rd && paddr == DTC_OFS_WORD_HIGH) |=> (s_q.low_buf == $past(cnt1[7:0]));
    endproperty
    a_latch: assert property (p_latch) else $error("low byte not latched");
    property p_pulse_end;
        @(posedge pclk) disable iff (!presetn)
        done0 |=> !c0.run;
    endproperty
    a_pulse_end: assert property (p_pulse_end) else $error("run not cleared");
    property p_div;
        @(posedge pclk) disable iff (!presetn)
        tick4 |=> !tick4 ##1 !tick4 ##1 !tick4 ##1 tick4;
    endproperty
    a_div: assert property (p_div) else $error("divider not by four");
    // Low byte reads return the buffer captured in the wait state
    property p_rd_low;
        @(posedge pclk) disable iff (!presetn)
        (rd && paddr == DTC_OFS_WORD_LOW) |=> (prdata[7:0] == $past(s_q.low_buf));
    endproperty
    a_rd_low: assert property (p_rd_low) else $error("low read not from buffer");
    property p_flag_set0;
        @(posedge pclk) disable iff (!presetn)
        ovf0 |=> s_q.if0;
    endproperty
    a_flag_set0: assert property (p_flag_set0) else $error("byte flag lost");
    property p_irq_gate1;
        @(posedge pclk) disable iff (!presetn)
        (!s_q.ie1) |-> !irq_word;
    endproperty
    a_irq_gate1: assert property (p_irq_gate1) else $error("word irq not gated");
    property p_pulse_end1;
        @(posedge pclk) disable iff (!presetn)
        done1 |=> !c1.run;
    endproperty
    a_pulse_end1: assert property (p_pulse_end1) else $error("word run not cleared");
    c_wake: cover property (@(posedge pclk) disable iff (!presetn) wakeup);
    c_irq: cover property (@(posedge pclk) disable iff (!presetn) irq_word);
endmodule
`default_nettype wire

// ==== dv/dtc_pin_model.sv ====
/*
 External timer pin source for the dual timer/event counter bench.
 Assumes pclk is shared with the design; levels change just after rising edges.
*/
`default_nettype none
module dtc_pin_model
(
    input wire logic pclk,
    output logic byte_pin,
    output logic word_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    // ========================================
    // Pin levels
    initial
    begin
        byte_pin = 1'b0;
        word_pin = 1'b0;
    end
    // Set one pin and keep it for hold cycles; the pin is only ever an input
    task automatic drive(input logic sel, input logic lvl, input int hold);
        @(posedge pclk);
        if (sel)
            word_pin <= lvl;
        else
            byte_pin <= lvl;
        repeat (hold) @(posedge pclk);
    endtask
endmodule
`default_nettype wire

// ==== dv/tb_dual_timer_event_counter.sv ====
/*
 Self-checking bench for the dual timer/event counter over APB.
 Assumes APB with one wait state; prdata and pslverr are taken at the pready edge.
*/
`default_nettype none
module tb_dual_timer_event_counter;
    import dtc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, byte_pin, word_pin, irq_byte, irq_word, wakeup, err;
    logic [7:0] lo, hi;
    int miscompares = 0;
    int n_checks = 0;
    int cyc = 0;
    int last_wk = 0;
    int period = 0;
    int n_wk = 0;
    int v, k;
    // ========================================
    // Design and pin source
    dtc_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .byte_counter_pin(byte_pin), .word_counter_pin(word_pin),
        .irq_byte(irq_byte), .irq_word(irq_word), .wakeup(wakeup));
    dtc_pin_model PIN (.pclk(pclk), .byte_pin(byte_pin), .word_pin(word_pin));
    always #25 pclk = ~pclk;
    // Overflow period monitor and timeout
    always @(posedge pclk)
    begin
        cyc++;
        if (wakeup === 1'b1)
        begin
            period = cyc - last_wk;
            last_wk = cyc;
            n_wk++;
        end
        if (cyc == 30000)
        begin
            miscompares++;
            finish_test();
        end
    end
    // ========================================
    // Tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        err = pslverr;
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        // Let the completing edge settle before the caller looks at outputs
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d});
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd, exp);
    endtask
    task automatic wait_wk(input int n);
        int target;
        target = n_wk + n;
        while (n_wk < target)
            @(posedge pclk);
    endtask
    task finish_test;
        $display("TB: checks=%0d miscompares=%0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // ========================================
    // Main sequence
    initial
    begin
        void'($urandom(37));
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rchk(DTC_OFS_BYTE_CTRL, 32'h0);
        rchk(DTC_OFS_WORD_CTRL, 32'h0);
        rchk(DTC_OFS_INT_CTRL, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        check({31'h0, err}, 32'h1);
        $display("TB: reset test done");
        // Byte timer period, reload and running preload
        wr(DTC_OFS_BYTE_VALUE, 8'hFA);
        rchk(DTC_OFS_BYTE_VALUE, 32'hFA);
        wr(DTC_OFS_BYTE_CTRL, 8'h90);
        wait_wk(2);
        check(period, 6);
        wr(DTC_OFS_BYTE_VALUE, 8'hF0);
        wait_wk(3);
        check(period, 16);
        wr(DTC_OFS_BYTE_CTRL, 8'h80);
        apb(1'b0, DTC_OFS_BYTE_VALUE, 32'h0);
        v = rd;
        repeat (20) @(posedge pclk);
        rchk(DTC_OFS_BYTE_VALUE, v);
        rchk(DTC_OFS_INT_CTRL, 32'h4);
        check({31'h0, irq_byte}, 32'h0);
        wr(DTC_OFS_INT_CTRL, 8'h05);
        check({31'h0, irq_byte}, 32'h1);
        wr(DTC_OFS_INT_CTRL, 8'h01);
        check({31'h0, irq_byte}, 32'h0);
        wr(DTC_OFS_BYTE_CTRL, 8'h10);
        PIN.drive(1'b0, 1'b1, 3);
        PIN.drive(1'b0, 1'b0, 3);
        rchk(DTC_OFS_BYTE_VALUE, v);
        $display("TB: byte timer test done");
        // Word counter byte buffering, random data
        lo = 8'($urandom);
        hi = 8'($urandom);
        wr(DTC_OFS_WORD_LOW, lo);
        rchk(DTC_OFS_WORD_HIGH, 32'h0);
        rchk(DTC_OFS_WORD_LOW, 32'h0);
        wr(DTC_OFS_WORD_LOW, lo);
        wr(DTC_OFS_WORD_HIGH, hi);
        rchk(DTC_OFS_WORD_HIGH, {24'h0, hi});
        rchk(DTC_OFS_WORD_LOW, {24'h0, lo});
        wr(DTC_OFS_WORD_LOW, 8'hF0);
        wr(DTC_OFS_WORD_HIGH, 8'hFF);
        wr(DTC_OFS_WORD_CTRL, 8'h90);
        wait_wk(2);
        check(period, 64);
        apb(1'b0, DTC_OFS_WORD_HIGH, 32'h0);
        apb(1'b0, DTC_OFS_WORD_LOW, 32'h0);
        v = rd;
        repeat (10) @(posedge pclk);
        rchk(DTC_OFS_WORD_LOW, v);
        wr(DTC_OFS_WORD_CTRL, 8'h00);
        rchk(DTC_OFS_INT_CTRL, 32'h9);
        check({31'h0, irq_word}, 32'h0);
        wr(DTC_OFS_INT_CTRL, 8'h0A);
        check({31'h0, irq_word}, 32'h1);
        $display("TB: word counter test done");
        // Event counting on each edge select
        wr(DTC_OFS_BYTE_CTRL, 8'h00);
        for (int e = 0; e < 2; e++)
        begin
            wr(DTC_OFS_BYTE_VALUE, 8'h10);
            wr(DTC_OFS_BYTE_CTRL, (e == 0) ? 8'h50 : 8'h58);
            PIN.drive(1'b0, 1'b1, 3);
            rchk(DTC_OFS_BYTE_VALUE, (e == 0) ? 32'h11 : 32'h10);
            PIN.drive(1'b0, 1'b0, 3);
            rchk(DTC_OFS_BYTE_VALUE, 32'h11);
            wr(DTC_OFS_BYTE_CTRL, 8'h00);
        end
        wr(DTC_OFS_BYTE_VALUE, 8'hFF);
        wr(DTC_OFS_BYTE_CTRL, 8'h50);
        k = n_wk;
        PIN.drive(1'b0, 1'b1, 3);
        PIN.drive(1'b0, 1'b0, 3);
        check(n_wk - k, 1);
        rchk(DTC_OFS_BYTE_VALUE, 32'hFF);
        wr(DTC_OFS_BYTE_CTRL, 8'h00);
        $display("TB: event test done");
        // Pulse width measurement, rising active edge
        wr(DTC_OFS_BYTE_VALUE, 8'h00);
        wr(DTC_OFS_BYTE_CTRL, 8'hD8);
        repeat (5) @(posedge pclk);
        rchk(DTC_OFS_BYTE_VALUE, 32'h0);
        PIN.drive(1'b0, 1'b1, 10);
        PIN.drive(1'b0, 1'b0, 4);
        apb(1'b0, DTC_OFS_BYTE_VALUE, 32'h0);
        v = rd;
        check({31'h0, v >= 10 && v <= 12}, 32'h1);
        rchk(DTC_OFS_STATUS, 32'h0);
        rchk(DTC_OFS_BYTE_CTRL, 32'hC8);
        PIN.drive(1'b0, 1'b1, 5);
        PIN.drive(1'b0, 1'b0, 3);
        rchk(DTC_OFS_BYTE_VALUE, v);
        $display("TB: pulse test done");
        finish_test();
    end
endmodule
`default_nettype wire
